/* src/vpic_pkg.sv */
// shared constants and types of the vectored priority interrupt controller
package vpic_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_SRC   = 24;
  localparam int NUM_GRP   = 6;
  localparam int NUM_LVL   = 4;
  localparam int NUM_EXT   = 12;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_EDGE_LOW    = 8'hA4;
  localparam logic [7:0] OFS_EDGE_HIGH   = 8'hA5;
  localparam logic [7:0] OFS_FLAG_SECOND = 8'hA6;
  localparam logic [7:0] OFS_EDGE_SECOND = 8'hA7;
  localparam logic [7:0] OFS_EN_FIRST    = 8'hA8;
  localparam logic [7:0] OFS_EN_SECOND   = 8'hA9;
  localparam logic [7:0] OFS_EN_THIRD    = 8'hAA;
  localparam logic [7:0] OFS_EN_FOURTH   = 8'hAB;
  localparam logic [7:0] OFS_PRIO_LOW    = 8'hB8;
  localparam logic [7:0] OFS_FLAG_FIRST  = 8'hC0;
  localparam logic [7:0] OFS_PRIO_HIGH   = 8'hF8;
  localparam logic [7:0] OFS_REQ_FIRST   = 8'hD9;
  localparam logic [7:0] OFS_REQ_SECOND  = 8'hDA;
  localparam logic [7:0] OFS_REQ_THIRD   = 8'hDB;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         GLOBAL_EN_BIT   = 7;
  localparam int         SRC_EN_W        = 6;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ----------------------------------------------------------------------
  // vectors and source mapping
  // ----------------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [7:0]  VEC_BASE       = 8'h03;
  localparam int          SRC_EXT_BANK   = 5;
  localparam int          SRC_EXT_EIGHT  = 6;
  localparam int          SRC_EXT_TEN    = 0;
  localparam int          SRC_EXT_ELEVEN = 1;
  localparam int          SRC_EXT_TWELVE = 11;

  // ----------------------------------------------------------------------
  // edge selection codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  // ----------------------------------------------------------------------
  // core timing
  // ----------------------------------------------------------------------
  localparam int MCYCLE_CLKS   = 2;
  localparam int CALL_MCYCLES  = 3;

  typedef enum logic [1:0] {
    CORE_RUN  = 2'h0,
    CORE_ACK  = 2'h1,
    CORE_CALL = 2'h3
  } vpic_core_state_type;

endpackage

/* src/vpic_link_if.sv */
// link between the interrupt controller and the cpu core
`timescale 1ns/1ps
interface vpic_link_if
(
  input wire logic core_clk_in,
  input wire logic reset_n_in
);
  // register access from the core
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  // interrupt handshake
  logic       instr_last;
  logic       irq_req;
  logic [7:0] vector_low_byte;
  logic       int_ack;
  logic       irq_return;

  modport dev
  (
    input  reg_addr, reg_wdata, reg_wr, reg_rd, instr_last, int_ack,
    input  irq_return,
    output reg_rdata, irq_req, vector_low_byte
  );

  modport core
  (
    output reg_addr, reg_wdata, reg_wr, reg_rd, instr_last, int_ack,
    output irq_return,
    input  reg_rdata, irq_req, vector_low_byte
  );
endinterface

/* src/vpic_ctrl.sv */
// device end: the vectored priority interrupt controller
// What this block does
// - six groups: group k holds k,k+6,k+12,k+18
// - group level from one bit of each priority register
// - both priority registers reset to zero
// - equal level: lower source index wins
// - higher level presented before lower level
// - preempt service only with strictly higher level
// - vector 0003H plus eight per source; reset 0000H
// - global enable plus 24 individual source enables
// - request passes only with global and source enable
// - global enable cleared on vectoring, set on return
// - request flag set, held, cleared on acceptance
// - latched request held until accepted or cleared
// - requests sampled in last instruction cycle
// - low vector byte decided, acknowledged next cycle
// - response latency three to nine machine cycles
// - service routine ends with return instruction
// - external lines feed sources 5,6,0,1,11
// - two-bit edge selection, no edge after reset
// - edge code 00 none,01 rise,10 fall,11 both
// - external flag set on edge, cleared on service
// - writing one to external flags does nothing
`timescale 1ns/1ps
module vpic_ctrl
(
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_n_in,
  // link to the cpu core
  vpic_link_if.dev                        link,
  // peripheral request pulses, one per source
  input  wire logic [vpic_pkg::NUM_SRC-1:0] irq_src_in,
  // external lines 0-7, 8, 10, 11, 12 in bits 0..11
  input  wire logic [vpic_pkg::NUM_EXT-1:0] ext_line_in,
  // status
  output logic      [3:0]                 active_levels_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                           glob_en;
    logic [vpic_pkg::NUM_SRC-1:0]   src_en;
    logic [vpic_pkg::NUM_GRP-1:0]   prio_lo;
    logic [vpic_pkg::NUM_GRP-1:0]   prio_hi;
    logic [2*vpic_pkg::NUM_EXT-1:0] pol;
    logic [vpic_pkg::NUM_EXT-1:0]   flag;
    logic [vpic_pkg::NUM_SRC-1:0]   req;
    logic [vpic_pkg::NUM_EXT-1:0]   sync1;
    logic [vpic_pkg::NUM_EXT-1:0]   sync2;
    logic [vpic_pkg::NUM_EXT-1:0]   prev;
    logic [3:0]                     active;
    logic                           irq;
    logic [7:0]                     vec;
    logic [4:0]                     sel;
    logic [1:0]                     sel_lvl;
    logic [7:0]                     rdata;
  } vpic_dev_type;

  vpic_dev_type s_r;
  vpic_dev_type s_nxt;

  logic [vpic_pkg::NUM_SRC-1:0] pend;
  logic [vpic_pkg::NUM_SRC-1:0] elig;
  logic [vpic_pkg::NUM_EXT-1:0] hit;
  logic                         act_any;
  logic [1:0]                   act_lvl;
  logic                         found;
  logic [1:0]                   best_lvl;
  logic [4:0]                   best_idx;
  logic [1:0]                   lvl;
  logic [1:0]                   esel;
  logic [7:0]                   wd;

  always_comb
  begin
    s_nxt    = s_r;
    wd       = link.reg_wdata;
    act_any  = 1'b0;
    act_lvl  = 2'h0;
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 5'h00;
    lvl      = 2'h0;
    esel     = 2'h0;

    // ----------------------------------------------------------------------
    // pending and eligible sources
    // ----------------------------------------------------------------------
    pend = s_r.req;
    pend[vpic_pkg::SRC_EXT_BANK]   = |s_r.flag[7:0];
    pend[vpic_pkg::SRC_EXT_EIGHT]  = s_r.flag[8];
    pend[vpic_pkg::SRC_EXT_TEN]    = s_r.flag[9];
    pend[vpic_pkg::SRC_EXT_ELEVEN] = s_r.flag[10];
    pend[vpic_pkg::SRC_EXT_TWELVE] = s_r.flag[11];
    elig = pend & s_r.src_en & {vpic_pkg::NUM_SRC{s_r.glob_en}};

    for (int l = 0; l < vpic_pkg::NUM_LVL; l++)
    begin
      if (s_r.active[l])
      begin
        act_any = 1'b1;
        act_lvl = 2'(l);
      end
    end

    // ----------------------------------------------------------------------
    // arbitration: highest level first, lowest index on a tie
    // ----------------------------------------------------------------------
    for (int i = 0; i < vpic_pkg::NUM_SRC; i++)
    begin
      lvl = {s_r.prio_hi[i % vpic_pkg::NUM_GRP],
             s_r.prio_lo[i % vpic_pkg::NUM_GRP]};
      if (elig[i] && (!act_any || lvl > act_lvl) &&
          (!found || lvl > best_lvl))
      begin
        found    = 1'b1;
        best_lvl = lvl;
        best_idx = 5'(i);
      end
    end

    // ----------------------------------------------------------------------
    // line synchroniser and edge detection
    // ----------------------------------------------------------------------
    s_nxt.sync1 = ext_line_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    for (int j = 0; j < vpic_pkg::NUM_EXT; j++)
    begin
      esel   = s_r.pol[2*j +: 2];
      hit[j] = ((esel == vpic_pkg::EDGE_RISE ||
                 esel == vpic_pkg::EDGE_BOTH) &&
                s_r.sync2[j] && !s_r.prev[j]) ||
               ((esel == vpic_pkg::EDGE_FALL ||
                 esel == vpic_pkg::EDGE_BOTH) &&
                !s_r.sync2[j] && s_r.prev[j]);
    end

    // ----------------------------------------------------------------------
    // register reads, answered one cycle after the strobe
    // ----------------------------------------------------------------------
    s_nxt.rdata = vpic_pkg::REG_RESET;
    if (link.reg_rd)
    begin
      unique case (link.reg_addr)
        vpic_pkg::OFS_EDGE_LOW:    s_nxt.rdata = s_r.pol[7:0];
        vpic_pkg::OFS_EDGE_HIGH:   s_nxt.rdata = s_r.pol[15:8];
        vpic_pkg::OFS_EDGE_SECOND: s_nxt.rdata = s_r.pol[23:16];
        vpic_pkg::OFS_FLAG_FIRST:  s_nxt.rdata = s_r.flag[7:0];
        vpic_pkg::OFS_FLAG_SECOND: s_nxt.rdata = {4'h0, s_r.flag[11:8]};
        vpic_pkg::OFS_EN_FIRST:
          s_nxt.rdata = {s_r.glob_en, 1'b0, s_r.src_en[5:0]};
        vpic_pkg::OFS_EN_SECOND:   s_nxt.rdata = {2'h0, s_r.src_en[11:6]};
        vpic_pkg::OFS_EN_THIRD:    s_nxt.rdata = {2'h0, s_r.src_en[17:12]};
        vpic_pkg::OFS_EN_FOURTH:   s_nxt.rdata = {2'h0, s_r.src_en[23:18]};
        vpic_pkg::OFS_PRIO_LOW:    s_nxt.rdata = {2'h0, s_r.prio_lo};
        vpic_pkg::OFS_PRIO_HIGH:   s_nxt.rdata = {2'h0, s_r.prio_hi};
        vpic_pkg::OFS_REQ_FIRST:   s_nxt.rdata = {2'h0, pend[5:0]};
        vpic_pkg::OFS_REQ_SECOND:  s_nxt.rdata = {2'h0, pend[11:6]};
        vpic_pkg::OFS_REQ_THIRD:   s_nxt.rdata = pend[19:12];
        default:                   s_nxt.rdata = vpic_pkg::REG_RESET;
      endcase
    end

    // ----------------------------------------------------------------------
    // register writes; flag and request writes only clear
    // ----------------------------------------------------------------------
    if (link.reg_wr)
    begin
      unique case (link.reg_addr)
        vpic_pkg::OFS_EDGE_LOW:    s_nxt.pol[7:0]   = wd;
        vpic_pkg::OFS_EDGE_HIGH:   s_nxt.pol[15:8]  = wd;
        vpic_pkg::OFS_EDGE_SECOND: s_nxt.pol[23:16] = wd;
        vpic_pkg::OFS_FLAG_FIRST:
          s_nxt.flag[7:0] = s_r.flag[7:0] & wd;
        vpic_pkg::OFS_FLAG_SECOND:
          s_nxt.flag[11:8] = s_r.flag[11:8] & wd[3:0];
        vpic_pkg::OFS_EN_FIRST:
        begin
          s_nxt.glob_en     = wd[vpic_pkg::GLOBAL_EN_BIT];
          s_nxt.src_en[5:0] = wd[5:0];
        end
        vpic_pkg::OFS_EN_SECOND:   s_nxt.src_en[11:6]  = wd[5:0];
        vpic_pkg::OFS_EN_THIRD:    s_nxt.src_en[17:12] = wd[5:0];
        vpic_pkg::OFS_EN_FOURTH:   s_nxt.src_en[23:18] = wd[5:0];
        vpic_pkg::OFS_PRIO_LOW:    s_nxt.prio_lo = wd[5:0];
        vpic_pkg::OFS_PRIO_HIGH:   s_nxt.prio_hi = wd[5:0];
        vpic_pkg::OFS_REQ_FIRST:
          s_nxt.req[5:0] = s_r.req[5:0] & wd[5:0];
        vpic_pkg::OFS_REQ_SECOND:
          s_nxt.req[11:6] = s_r.req[11:6] & wd[5:0];
        vpic_pkg::OFS_REQ_THIRD:
          s_nxt.req[19:12] = s_r.req[19:12] & wd;
        default:
        begin
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // handshake with the core
    // ----------------------------------------------------------------------
    if (link.int_ack && s_r.irq)
    begin
      s_nxt.irq              = 1'b0;
      s_nxt.glob_en          = 1'b0;
      s_nxt.active[s_r.sel_lvl] = 1'b1;
      s_nxt.req[s_r.sel]     = 1'b0;
      unique case (int'(s_r.sel))
        vpic_pkg::SRC_EXT_BANK:   s_nxt.flag[7:0] = 8'h00;
        vpic_pkg::SRC_EXT_EIGHT:  s_nxt.flag[8]   = 1'b0;
        vpic_pkg::SRC_EXT_TEN:    s_nxt.flag[9]   = 1'b0;
        vpic_pkg::SRC_EXT_ELEVEN: s_nxt.flag[10]  = 1'b0;
        vpic_pkg::SRC_EXT_TWELVE: s_nxt.flag[11]  = 1'b0;
        default:
        begin
        end
      endcase
    end
    else if (link.instr_last)
    begin
      // re-evaluated each instruction end so a withdrawn request drops out
      s_nxt.irq     = found;
      s_nxt.sel     = best_idx;
      s_nxt.sel_lvl = best_lvl;
      s_nxt.vec     = vpic_pkg::VEC_BASE + {best_idx, 3'h0};
    end

    if (link.irq_return)
    begin
      s_nxt.glob_en = 1'b1;
      if (act_any)
        s_nxt.active[act_lvl] = 1'b0;
    end

    // ----------------------------------------------------------------------
    // sets last so an event beats a clear in the same cycle
    // ----------------------------------------------------------------------
    s_nxt.req  = s_nxt.req | irq_src_in;
    s_nxt.flag = s_nxt.flag | hit;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign link.reg_rdata       = s_r.rdata;
  assign link.irq_req         = s_r.irq;
  assign link.vector_low_byte = s_r.vec;
  assign active_levels_out    = s_r.active;

endmodule // vpic_ctrl

/* src/vpic_core_end.sv */
// core end: acknowledges interrupts and performs the vectoring call
`timescale 1ns/1ps
module vpic_core_end
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // link to the controller
  vpic_link_if.core        link,
  // software register port
  input  wire logic [7:0]  sw_addr_in,
  input  wire logic [7:0]  sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic      [7:0]  sw_rdata_out,
  // instruction sequencing
  input  wire logic        instr_end_in,
  input  wire logic        ret_exec_in,
  // service entry
  output logic             call_busy_out,
  output logic             isr_entry_out,
  output logic      [15:0] isr_addr_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    vpic_pkg::vpic_core_state_type st;
    logic [1:0]                    mdiv;
    logic [1:0]                    mcnt;
    logic                          ack;
    logic                          ret;
    logic                          entry;
    logic                          busy;
    logic [15:0]                   addr;
  } vpic_core_type;

  vpic_core_type c_r;
  vpic_core_type c_nxt;
  logic          mtick;

  always_comb
  begin
    c_nxt       = c_r;
    mtick       = (c_r.mdiv == 2'(vpic_pkg::MCYCLE_CLKS - 1));
    c_nxt.mdiv  = mtick ? 2'h0 : c_r.mdiv + 2'h1;
    c_nxt.ack   = 1'b0;
    c_nxt.entry = 1'b0;
    c_nxt.ret   = ret_exec_in;
    unique case (c_r.st)
      vpic_pkg::CORE_RUN:
      begin
        // no new acceptance in the cycle the return pulse goes out
        if (instr_end_in && link.irq_req && !c_r.ret)
        begin
          c_nxt.st   = vpic_pkg::CORE_ACK;
          c_nxt.ack  = 1'b1;
          c_nxt.busy = 1'b1;
        end
      end
      vpic_pkg::CORE_ACK:
      begin
        c_nxt.addr = {8'h00, link.vector_low_byte};
        c_nxt.mcnt = 2'h0;
        c_nxt.st   = vpic_pkg::CORE_CALL;
      end
      vpic_pkg::CORE_CALL:
      begin
        if (mtick)
        begin
          if (c_r.mcnt == 2'(vpic_pkg::CALL_MCYCLES - 1))
          begin
            c_nxt.st    = vpic_pkg::CORE_RUN;
            c_nxt.entry = 1'b1;
            c_nxt.busy  = 1'b0;
          end
          else
            c_nxt.mcnt = c_r.mcnt + 2'h1;
        end
      end
      default:
        c_nxt.st = vpic_pkg::CORE_RUN;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      c_r      <= '0;
      c_r.addr <= vpic_pkg::RESET_VECTOR;
    end
    else
      c_r <= c_nxt;
  end

  // register strobes pass straight through so read data keeps its cycle
  assign link.reg_addr    = sw_addr_in;
  assign link.reg_wdata   = sw_wdata_in;
  assign link.reg_wr      = sw_wr_in;
  assign link.reg_rd      = sw_rd_in;
  assign link.instr_last  = instr_end_in;
  assign link.int_ack     = c_r.ack;
  assign link.irq_return  = c_r.ret;
  assign sw_rdata_out     = link.reg_rdata;
  assign call_busy_out    = c_r.busy;
  assign isr_entry_out    = c_r.entry;
  assign isr_addr_out     = c_r.addr;

endmodule // vpic_core_end

/* test/vpic_link_asserts.sv */
// concurrent checks on the link between controller and core end
`timescale 1ns/1ps
module vpic_link_asserts
(
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  // interrupt handshake
  input wire logic       instr_last,
  input wire logic       irq_req,
  input wire logic [7:0] vector_low_byte,
  input wire logic       int_ack,
  input wire logic       irq_return
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------------------------------------
  // handshake steps
  // ----------------------------------------------------------------------
  sequence s_offer;
    irq_req && instr_last && !int_ack && !irq_return;
  endsequence
  sequence s_take;
    int_ack ##1 !irq_req;
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  offer_gets_ack_a: assert property (
    s_offer |=> s_take) else $error("offered request not acknowledged");
  ack_has_cause_a: assert property (
    int_ack |-> $past(irq_req) && $past(instr_last))
    else $error("acknowledge without offered request");
  ack_spacing_a: assert property (
    int_ack |=> !int_ack [*6]) else $error("acknowledge during vectoring call");
  vector_align_a: assert property (
    irq_req |-> vector_low_byte[2:0] == 3'h3 && vector_low_byte <= 8'hBB)
    else $error("vector byte off the table");
  vector_hold_a: assert property (
    irq_req && !instr_last && !int_ack |=> $stable(vector_low_byte))
    else $error("vector byte changed between samples");
  return_pulse_a: assert property (
    irq_return |=> !irq_return) else $error("return pulse too long");
  req_rise_a: assert property (
    $rose(irq_req) |-> $past(instr_last))
    else $error("request raised outside instruction end");
  req_fall_a: assert property (
    $fell(irq_req) |-> $past(int_ack) || $past(instr_last))
    else $error("request withdrawn without cause");
endmodule // vpic_link_asserts

/* test/vectored_priority_interrupt_ctrl_tb_top.sv */
// self-checking bench joining controller and core end
`timescale 1ns/1ps
module vectored_priority_interrupt_ctrl_tb_top;
  typedef struct {int src; logic [15:0] vec; logic [3:0] lvl;} vpic_row_type;
  logic        core_clk_in       = 1'b0;
  logic        reset_n_in        = 1'b0;
  logic [7:0]  sw_addr_in        = 8'h00;
  logic [7:0]  sw_wdata_in       = 8'h00;
  logic        sw_wr_in          = 1'b0;
  logic        sw_rd_in          = 1'b0;
  logic        instr_end_in      = 1'b0;
  logic        ret_exec_in       = 1'b0;
  logic [23:0] irq_src_in        = 24'h000000;
  logic [11:0] ext_line_in       = 12'h000;
  logic        run_en            = 1'b0;
  logic [7:0]  sw_rdata_out;
  logic        call_busy_out;
  logic        isr_entry_out;
  logic [15:0] isr_addr_out;
  logic [3:0]  active_levels_out;
  int          miscompares       = 0;
  int          total_checks      = 0;
  int          entries           = 0;
  logic [7:0]  regs [12] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9,
                             8'hAA, 8'hAB, 8'hB8, 8'hC0, 8'hF8, 8'h10};
  // levels follow priority low 24H, high 28H set before the loop
  vpic_row_type rows [8] = '{'{2, 16'h0013, 4'h2}, '{4, 16'h0023, 4'h1},
    '{7, 16'h003B, 4'h1}, '{12, 16'h0063, 4'h1}, '{17, 16'h008B, 4'h8},
    '{18, 16'h0093, 4'h1}, '{21, 16'h00AB, 4'h4}, '{23, 16'h00BB, 4'h8}};

  vpic_link_if link (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in));
  vpic_ctrl i_vpic_ctrl (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .link(link), .irq_src_in(irq_src_in), .ext_line_in(ext_line_in),
    .active_levels_out(active_levels_out));
  vpic_core_end i_vpic_core_end (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .link(link), .sw_addr_in(sw_addr_in),
    .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
    .sw_rdata_out(sw_rdata_out), .instr_end_in(instr_end_in),
    .ret_exec_in(ret_exec_in), .call_busy_out(call_busy_out),
    .isr_entry_out(isr_entry_out), .isr_addr_out(isr_addr_out));
  vpic_link_asserts i_vpic_link_asserts (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .instr_last(link.instr_last),
    .irq_req(link.irq_req), .vector_low_byte(link.vector_low_byte),
    .int_ack(link.int_ack), .irq_return(link.irq_return));

  // ----------------------------------------------------------------------
  // clock, instruction stream and entry counter
  // ----------------------------------------------------------------------
  always #50 core_clk_in = ~core_clk_in;
  // one-cycle instructions, paused while the vectoring call runs
  always @(posedge core_clk_in) instr_end_in <= run_en && !call_busy_out;
  always @(posedge core_clk_in)
    if (isr_entry_out === 1'b1)
      entries <= entries + 1;

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    sw_addr_in  <= a;
    sw_wdata_in <= d;
    sw_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    sw_wr_in    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string nm);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    sw_rd_in   <= 1'b0;
    #1;
    check(nm, {8'h00, sw_rdata_out}, {8'h00, exp});
  endtask
  task automatic pulse(input logic [23:0] m);
    @(posedge core_clk_in);
    irq_src_in <= m;
    @(posedge core_clk_in);
    irq_src_in <= 24'h000000;
  endtask
  task automatic ext(input logic [11:0] v);
    @(posedge core_clk_in);
    ext_line_in <= v;
  endtask
  task automatic ret;
    @(posedge core_clk_in);
    ret_exec_in <= 1'b1;
    @(posedge core_clk_in);
    ret_exec_in <= 1'b0;
  endtask
  task automatic quiet;
    int e = entries;
    idle(20);
    check("no_entry", 16'(entries - e), 16'h0000);
  endtask
  task automatic wait_entry(input logic [15:0] exp, input logic [3:0] lvl);
    int n = 0;
    do
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    while (isr_entry_out !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      miscompares++;
      give_verdict();
    end
    check("isr_addr", isr_addr_out, exp);
    check("active", {12'h000, active_levels_out}, {12'h000, lvl});
    check("latency", {15'h0000, n >= 6 && n <= 20}, 16'h0001);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    run_en     <= 1'b1;
    wr(8'h10, 8'hFF);
    foreach (regs[i]) rd_chk(regs[i], 8'h00, "reset_value");
    for (int i = 0; i < 4; i++)
      wr(8'(8'hA8 + i), i == 0 ? 8'hBF : 8'h3F);
    wr(8'hB8, 8'h24);
    wr(8'hF8, 8'h28);
    rd_chk(8'hF8, 8'h28, "prio_high");
    foreach (rows[i])
    begin
      pulse(24'h000001 << rows[i].src);
      wait_entry(rows[i].vec, rows[i].lvl);
      rd_chk(8'hA8, 8'h3F, "global_off");
      ret();
      rd_chk(8'hA8, 8'hBF, "global_on");
    end
    wr(8'hA8, 8'h3F);
    pulse(24'h000008);
    quiet();
    rd_chk(8'hD9, 8'h08, "pending");
    wr(8'hD9, 8'h00);
    rd_chk(8'hD9, 8'h00, "withdrawn");
    wr(8'hA8, 8'hBF);
    wr(8'hA9, 8'h00);
    pulse(24'h000080);
    quiet();
    rd_chk(8'hDA, 8'h02, "held");
    wr(8'hA9, 8'h3F);
    wait_entry(16'h003B, 4'h1);
    ret();
    pulse(24'h008004);
    wait_entry(16'h007B, 4'h4);
    ret();
    wait_entry(16'h0013, 4'h2);
    wr(8'hA8, 8'hBF);
    pulse(24'h000110);
    quiet();
    pulse(24'h200000);
    wait_entry(16'h00AB, 4'h6);
    ret();
    quiet();
    ret();
    wait_entry(16'h0043, 4'h2);
    ret();
    wait_entry(16'h0023, 4'h1);
    ret();
    pulse(24'h001010);
    wait_entry(16'h0023, 4'h1);
    ret();
    wait_entry(16'h0063, 4'h1);
    ret();
    wr(8'hA8, 8'h3F);
    wr(8'hA4, 8'h01);
    ext(12'h001);
    idle(6);
    rd_chk(8'hC0, 8'h01, "flag_set");
    wr(8'hC0, 8'hFF);
    rd_chk(8'hC0, 8'h01, "flag_keep");
    wr(8'hC0, 8'h00);
    rd_chk(8'hC0, 8'h00, "flag_clear");
    ext(12'h000);
    idle(6);
    rd_chk(8'hC0, 8'h00, "no_fall");
    wr(8'hA8, 8'hBF);
    ext(12'h001);
    wait_entry(16'h002B, 4'h8);
    rd_chk(8'hC0, 8'h00, "flag_auto");
    ret();
    wr(8'hA7, 8'h4F);
    ext(12'h201);
    wait_entry(16'h0003, 4'h1);
    ret();
    ext(12'h301);
    wait_entry(16'h0033, 4'h1);
    ret();
    ext(12'hB01);
    wait_entry(16'h005B, 4'h8);
    ret();
    ext(12'h801);
    // lines 8 and 10 fall together: the lower source goes first
    wait_entry(16'h0003, 4'h1);
    ret();
    // stall the instruction stream so the offer must stand unanswered
    @(posedge core_clk_in);
    run_en <= 1'b0;
    idle(4);
    check("req_held", {15'h0000, link.irq_req}, 16'h0001);
    run_en <= 1'b1;
    wait_entry(16'h0033, 4'h1);
    // ----------------------------------------------------------------------
    // reset in mid-service
    // ----------------------------------------------------------------------
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    idle(2);
    check("rst_addr", isr_addr_out, 16'h0000);
    check("rst_active", {12'h000, active_levels_out}, 16'h0000);
    @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    rd_chk(8'hA8, 8'h00, "rst_enable");
    rd_chk(8'hB8, 8'h00, "rst_prio");
    give_verdict();
  end
endmodule // vectored_priority_interrupt_ctrl_tb_top
